// ==== rtl/lmac_pkg.sv ====
package lmac_pkg;
  // Timing base
  localparam int CLK_HZ = 125_000_000;
  localparam int OSC_HZ = 2_400_000;
  localparam int FRAME_OSC_PERIODS = (256 + 16) * 9;
  localparam int FRAME_CYCLES =
    int'((64'(FRAME_OSC_PERIODS) * 64'(CLK_HZ)) / 64'(OSC_HZ));
  localparam int PAGE_DELAY_UNIT = 8;
  localparam int SCROLL_UNIT = 32;
  localparam int SCROLL_COLUMNS = 9;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_MOVIE_START = 8'h11;
  localparam logic [7:0] IDX_LOOP_COUNT = 8'h13;
  localparam logic [7:0] IDX_PAGE_DELAY = 8'h14;
  localparam logic [7:0] IDX_LAST_PAGE = 8'h15;
  localparam logic [7:0] IDX_SCROLL = 8'h20;
  localparam logic [7:0] IDX_DISPLAY_MODE = 8'h30;
  localparam logic [7:0] IDX_PIXEL_DEPTH = 8'h31;
  localparam logic [7:0] IDX_FADE = 8'h32;
  localparam logic [7:0] IDX_STATUS = 8'h40;

  // Values after reset
  localparam logic [7:0] RST_MOVIE_START = 8'h00;
  localparam logic [7:0] RST_LOOP_COUNT = 8'h00;
  localparam logic [7:0] RST_PAGE_DELAY = 8'h04;
  localparam logic [7:0] RST_LAST_PAGE = 8'h00;
  localparam logic [7:0] RST_SCROLL = 8'h00;
  localparam logic [7:0] RST_DISPLAY_MODE = 8'h00;
  localparam logic [7:0] RST_PIXEL_DEPTH = 8'h00;
  localparam logic [7:0] RST_FADE = 8'h4a;

  // Field positions
  localparam int MOVIE_EN_POS = 7;
  localparam int ENDLESS_POS = 3;
  localparam int SCROLL_ON_POS = 7;
  localparam int SCROLL_DIR_POS = 5;
  localparam int DEPTH_POS = 7;
  localparam logic [3:0] GRAY_MAX_PAGE = 4'h1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic fade_on;
    logic intensity_curve;
    logic fade_scope;
    logic fade_out_length;
    logic [1:0] extinguish_length;
    logic [1:0] light_length;
  } lmac_fade_s;

  typedef struct packed {
    logic [9:0] light;
    logic [9:0] fade_out;
    logic [9:0] extinguish;
  } lmac_fade_times_s;

  typedef enum logic [1:0] {MV_IDLE, MV_PLAY, MV_DONE} lmac_movie_e;
endpackage

// ==== rtl/lmac_top.sv ====
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// - Code 14h loads page delay from bits 5:0, reset 04h.
// - Each movie page holds (delay+1)*8 frame times.
// - Frame time is (256+16)*9 oscillator periods; all timing counts frames.
// - Code 15h loads last page 0..15; gray allows only 0 and 1.
// - Undefined parameter values leave the setting unchanged.
// - Code 20h loads scroll on, direction and step period.
// - Scroll steps every (period+1)*32 frame times.
// - Scroll shifts the picture as a single row in the chosen direction.
// - Scrolling works only in gray mode, ignored in binary mode.
// - Code 30h bit 0 picks picture (0) or movie (1).
// - Code 31h bit 7 picks gray (0) or binary (1).
// - Code 32h fade byte, reset 4Ah, applies at next frame start.
// - Fade bit 7 enables, bit 5 picks per-dot or global fade.
// - Fade bit 6 picks linear or gamma column intensity.
// - Fade bit 4 sets fade-out time to T1 or twice T1.
// - Fade bits 3:2 set extinguish time as quarter to double T1.
// - Fade bits 1:0 set light time as quarter to double T1.
// - Base period T1 comes from the per-dot fade data.
// - No per-dot fading in binary mode.
// - Code 11h loads movie start page and movie enable, both reset zero.
// - Code 13h sets 1..8 loops, bit 3 endless until 0..7 written.
module lmac_top
  import lmac_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES,
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] t1_frames,
  output logic frame_tick,
  output logic [3:0] display_page,
  output logic movie_running,
  output logic [3:0] scroll_offset,
  output logic scroll_step,
  output lmac_fade_s fade_cfg,
  output lmac_fade_times_s fade_times,
  output logic per_dot_fade,
  output logic global_fade
);
  localparam int FW = $clog2(FRAME_LEN + 1);

  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic w_held;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_ok;
  logic [7:0] movie_start;
  logic [7:0] loop_count;
  logic [5:0] page_delay_field;
  logic [3:0] last_page_field;
  logic [7:0] scroll_reg;
  logic picture_or_movie;
  logic pixel_depth;
  lmac_fade_s fade_pending;
  logic [FW-1:0] frame_cnt;
  logic [9:0] delay_cnt;
  logic [9:0] page_frames;
  logic [2:0] loop_idx;
  lmac_movie_e movie_state;
  logic movie_go;
  logic page_end;
  logic [10:0] step_cnt;
  logic [10:0] step_frames;
  logic scroll_active;

  function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != '0) return 1'b0;
    return i == IDX_MOVIE_START || i == IDX_LOOP_COUNT || i == IDX_PAGE_DELAY ||
           i == IDX_LAST_PAGE || i == IDX_SCROLL || i == IDX_DISPLAY_MODE ||
           i == IDX_PIXEL_DEPTH || i == IDX_FADE || i == IDX_STATUS;
  endfunction

  function automatic logic [3:0] quarters(input logic [1:0] code);
    return 4'h1 << code;
  endfunction

  // Write channels taken independently, response after both
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[9:2];
  assign wr_ok = idx_mapped(aw_addr);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Each write to index N is command code N with its parameter byte
  always_ff @(posedge clock) begin
    if (rst) begin
      movie_start <= RST_MOVIE_START;
      loop_count <= RST_LOOP_COUNT;
      page_delay_field <= RST_PAGE_DELAY[5:0];
      last_page_field <= RST_LAST_PAGE[3:0];
      scroll_reg <= RST_SCROLL;
      picture_or_movie <= RST_DISPLAY_MODE[0];
      pixel_depth <= RST_PIXEL_DEPTH[DEPTH_POS];
      fade_pending <= lmac_fade_s'(RST_FADE);
    end else if (wr_fire && wr_ok && w_lane) begin
      unique case (wr_idx)
        IDX_MOVIE_START: begin
          // Gray mode has only two pages, others are not defined
          if (pixel_depth || w_byte[3:0] <= GRAY_MAX_PAGE) begin
            movie_start <= {w_byte[MOVIE_EN_POS], 3'b000, w_byte[3:0]};
          end
        end
        IDX_LOOP_COUNT: loop_count <= {4'h0, w_byte[3:0]};
        IDX_PAGE_DELAY: page_delay_field <= w_byte[5:0];
        IDX_LAST_PAGE: begin
          if (pixel_depth || w_byte[3:0] <= GRAY_MAX_PAGE) begin
            last_page_field <= w_byte[3:0];
          end
        end
        IDX_SCROLL: scroll_reg <= {w_byte[7], 1'b0, w_byte[5:0]};
        IDX_DISPLAY_MODE: picture_or_movie <= w_byte[0];
        IDX_PIXEL_DEPTH: pixel_depth <= w_byte[DEPTH_POS];
        IDX_FADE: fade_pending <= lmac_fade_s'(w_byte);
        default: ;
      endcase
    end
  end

  // Read channel, one read under way at a time
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= idx_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      if (idx_mapped(s_axi_araddr)) begin
        unique case (s_axi_araddr[9:2])
          IDX_MOVIE_START: s_axi_rdata[7:0] <= movie_start;
          IDX_LOOP_COUNT: s_axi_rdata[7:0] <= loop_count;
          IDX_PAGE_DELAY: s_axi_rdata[7:0] <= {2'b00, page_delay_field};
          IDX_LAST_PAGE: s_axi_rdata[7:0] <= {4'h0, last_page_field};
          IDX_SCROLL: s_axi_rdata[7:0] <= scroll_reg;
          IDX_DISPLAY_MODE: s_axi_rdata[7:0] <= {7'h00, picture_or_movie};
          IDX_PIXEL_DEPTH: s_axi_rdata[7:0] <= {pixel_depth, 7'h00};
          IDX_FADE: s_axi_rdata[7:0] <= fade_cfg;
          IDX_STATUS: s_axi_rdata[15:0] <= {2'b00, movie_state, movie_running,
                                             loop_idx, scroll_offset, display_page};
          default: ;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Frame time base; the oscillator itself is modelled by the clock rate
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_cnt <= '0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= (frame_cnt == FW'(FRAME_LEN - 1));
      frame_cnt <= (frame_cnt == FW'(FRAME_LEN - 1)) ? '0 : frame_cnt + 1'b1;
    end
  end

  // Movie sequencer
  assign page_frames = 10'(({4'h0, page_delay_field} + 10'h001) * PAGE_DELAY_UNIT);
  assign movie_go = picture_or_movie && movie_start[MOVIE_EN_POS];
  assign page_end = frame_tick && (delay_cnt == page_frames - 10'h001);
  assign movie_running = (movie_state == MV_PLAY);

  always_ff @(posedge clock) begin
    if (rst) begin
      movie_state <= MV_IDLE;
      display_page <= 4'h0;
      delay_cnt <= 10'h000;
      loop_idx <= 3'h0;
    end else if (!movie_go) begin
      movie_state <= MV_IDLE;
      display_page <= 4'h0;
      delay_cnt <= 10'h000;
      loop_idx <= 3'h0;
    end else begin
      unique case (movie_state)
        MV_IDLE: begin
          movie_state <= MV_PLAY;
          display_page <= movie_start[3:0];
          delay_cnt <= 10'h000;
          loop_idx <= 3'h0;
        end
        MV_PLAY: begin
          if (page_end) begin
            delay_cnt <= 10'h000;
            if (display_page == last_page_field) begin
              // Endless play stops only after a finite count is written
              if (!loop_count[ENDLESS_POS] && loop_idx >= loop_count[2:0]) begin
                movie_state <= MV_DONE;
              end else begin
                loop_idx <= loop_idx + 3'h1;
                display_page <= movie_start[3:0];
              end
            end else begin
              display_page <= display_page + 4'h1;
            end
          end else if (frame_tick) begin
            delay_cnt <= delay_cnt + 10'h001;
          end
        end
        MV_DONE: ;
      endcase
    end
  end

  // Single row scroll; binary mode masks the enable
  assign scroll_active = scroll_reg[SCROLL_ON_POS] && !pixel_depth;
  assign step_frames = 11'(({6'h00, scroll_reg[4:0]} + 11'h001) * SCROLL_UNIT);

  always_ff @(posedge clock) begin
    if (rst || !scroll_active) begin
      step_cnt <= 11'h000;
      scroll_step <= 1'b0;
      scroll_offset <= 4'h0;
    end else begin
      scroll_step <= 1'b0;
      if (frame_tick) begin
        if (step_cnt == step_frames - 11'h001) begin
          step_cnt <= 11'h000;
          scroll_step <= 1'b1;
          if (scroll_reg[SCROLL_DIR_POS]) begin
            scroll_offset <= (scroll_offset == 4'(SCROLL_COLUMNS - 1)) ? 4'h0
                             : scroll_offset + 4'h1;
          end else begin
            scroll_offset <= (scroll_offset == 4'h0) ? 4'(SCROLL_COLUMNS - 1)
                             : scroll_offset - 4'h1;
          end
        end else begin
          step_cnt <= step_cnt + 11'h001;
        end
      end
    end
  end

  // Fade byte is only adopted at frame start so a frame never mixes settings
  always_ff @(posedge clock) begin
    if (rst) begin
      fade_cfg <= lmac_fade_s'(RST_FADE);
    end else if (frame_tick) begin
      fade_cfg <= fade_pending;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      per_dot_fade <= 1'b0;
      global_fade <= 1'b0;
      fade_times <= '0;
    end else begin
      per_dot_fade <= fade_cfg.fade_on && !fade_cfg.fade_scope && !pixel_depth;
      global_fade <= fade_cfg.fade_on && fade_cfg.fade_scope;
      // Times in frames, scaled from T1; quarter of T1 truncates
      fade_times.light <= 10'(({4'h0, t1_frames} * quarters(fade_cfg.light_length)) >> 2);
      fade_times.extinguish <=
        10'(({4'h0, t1_frames} * quarters(fade_cfg.extinguish_length)) >> 2);
      fade_times.fade_out <= fade_cfg.fade_out_length ? {1'b0, t1_frames, 1'b0}
                             : {2'b00, t1_frames};
    end
  end

  // Helper counters watched only by the checks
  int cyc_since;
  logic tick_seen;
  logic [9:0] hold_frames;
  logic [10:0] scroll_frames;

  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_since <= 0;
      tick_seen <= 1'b0;
      hold_frames <= 10'h000;
      scroll_frames <= 11'h000;
    end else begin
      cyc_since <= frame_tick ? 0 : cyc_since + 1;
      tick_seen <= tick_seen || frame_tick;
      if (movie_state != MV_PLAY) begin
        hold_frames <= 10'h000;
      end else if (display_page != $past(display_page)) begin
        // A tick in the first cycle of a page already counts toward its delay
        hold_frames <= {9'h000, frame_tick};
      end else if (frame_tick) begin
        hold_frames <= hold_frames + 10'h001;
      end
      if (scroll_step || !scroll_active) begin
        scroll_frames <= 11'h000;
      end else if (frame_tick) begin
        scroll_frames <= scroll_frames + 11'h001;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_frame_period: assert property (
    frame_tick && tick_seen |-> cyc_since == FRAME_LEN - 1)
    else $error("frame tick spacing wrong");
  chk_delay_load: assert property (
    wr_fire && wr_ok && w_lane && wr_idx == IDX_PAGE_DELAY
    |=> page_delay_field == $past(w_byte[5:0]))
    else $error("page delay not loaded");
  chk_page_hold: assert property (
    movie_state == MV_PLAY && page_end && display_page != last_page_field
    |-> hold_frames == page_frames - 10'h001 ##1 display_page == $past(display_page) + 4'h1)
    else $error("movie page held wrong time");
  chk_gray_guard: assert property (
    wr_fire && wr_ok && w_lane && wr_idx == IDX_LAST_PAGE && !pixel_depth
    && w_byte[3:0] > GRAY_MAX_PAGE |=> $stable(last_page_field))
    else $error("undefined last page accepted");
  chk_scroll_period: assert property (
    scroll_step |-> $past(scroll_frames) == $past(step_frames) - 11'h001)
    else $error("scroll step period wrong");
  chk_scroll_binary: assert property (
    pixel_depth |=> !scroll_step && scroll_offset == 4'h0)
    else $error("scroll in binary mode");
  chk_picture_still: assert property (
    !picture_or_movie |=> !movie_running [*2])
    else $error("movie runs in picture mode");
  chk_fade_frame: assert property (
    !frame_tick |=> $stable(fade_cfg))
    else $error("fade byte applied mid frame");
  chk_perdot_binary: assert property (
    pixel_depth && $past(pixel_depth) |-> !per_dot_fade)
    else $error("per dot fade in binary mode");
  chk_write_resp: assert property (
    wr_fire |=> s_axi_bvalid && (s_axi_bresp == (wr_ok ? RESP_OKAY : RESP_SLVERR)) [*1])
    else $error("write response missing");
endmodule // lmac_top

// ==== dv/lmac_t1_source.sv ====
`timescale 1ns/1ns
module lmac_t1_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] value,
  output logic [7:0] t1_frames
);
  // Fade data side hands over T1 from a register on the block clock
  always_ff @(posedge clock) begin
    if (rst) begin
      t1_frames <= 8'h00;
    end else if (load) begin
      t1_frames <= value;
    end
  end
endmodule // lmac_t1_source

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import lmac_pkg::*;
  localparam int FL = 16;
  localparam logic [7:0] RIDX [8] = '{IDX_MOVIE_START, IDX_LOOP_COUNT, IDX_PAGE_DELAY,
    IDX_LAST_PAGE, IDX_SCROLL, IDX_DISPLAY_MODE, IDX_PIXEL_DEPTH, IDX_FADE};
  localparam logic [7:0] RVAL [8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4a};
  localparam logic [7:0] FIDX [5] = '{IDX_PAGE_DELAY, IDX_SCROLL, IDX_DISPLAY_MODE,
    IDX_PIXEL_DEPTH, IDX_LOOP_COUNT};
  localparam logic [7:0] FMSK [5] = '{8'h3f, 8'hbf, 8'h01, 8'h80, 8'h0f};
  localparam logic [3:0] FTOP [4] = '{4'h8, 4'h8, 4'ha, 4'h0};
  logic clock = 0;
  logic rst = 1;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, t1_load = 0;
  logic [31:0] wdata = 0;
  logic [7:0] t1_value = 0;
  logic awready, wready, bvalid, arready, rvalid, frame_tick, movie_running, scroll_step;
  logic per_dot_fade, global_fade;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] t1_frames;
  logic [3:0] display_page, scroll_offset;
  lmac_fade_s fade_cfg;
  lmac_fade_times_s fade_times;
  int fails = 0;
  int tests_run = 0;
  int seed = 32'h144f;

  lmac_t1_source i_t1 (.clock(clock), .rst(rst), .load(t1_load), .value(t1_value),
    .t1_frames(t1_frames));

  lmac_top #(.FRAME_LEN(FL)) i_dut (.clock(clock), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .t1_frames(t1_frames), .frame_tick(frame_tick), .display_page(display_page),
    .movie_running(movie_running), .scroll_offset(scroll_offset), .scroll_step(scroll_step),
    .fade_cfg(fade_cfg), .fade_times(fade_times), .per_dot_fade(per_dot_fade),
    .global_fade(global_fade));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      tally_and_finish;
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [9:0] part(input logic [7:0] t, input logic [1:0] c);
    logic [11:0] x;
    x = {4'h0, t} << c;
    return x[11:2];
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic aw;
    logic w;
    @(posedge clock);
    awaddr <= ba(idx);
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    aw = 1;
    w = 1;
    n = 0;
    while ((aw || w) && n < 50) begin
      @(posedge clock);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready === 1'b1) begin
        w = 0;
        wvalid <= 0;
      end
    end
    bound(n, 50);
    n = 0;
    while (bvalid !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    bound(n, 50);
    resp = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar;
    @(posedge clock);
    araddr <= ba(idx);
    arvalid <= 1;
    rready <= 1;
    ar = 1;
    n = 0;
    while (n < 50) begin
      @(posedge clock);
      n++;
      if (!ar && rvalid === 1'b1) break;
      if (ar && arready === 1'b1) begin
        ar = 0;
        arvalid <= 0;
      end
    end
    bound(n, 50);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask

  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    check(r, RESP_OKAY);
  endtask

  task automatic peek(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    check(r, RESP_OKAY);
    check(d, {24'h0, exp});
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return frame_tick;
      1: return scroll_step;
      2: return movie_running;
      default: return !movie_running;
    endcase
  endfunction

  // Counts edges up to the next one where the chosen signal is high
  task automatic wait_for(input int w, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sel(w) !== 1'b1 && n < 5000);
    bound(n, 5000);
  endtask

  task automatic wait_page(output int n);
    logic [3:0] p;
    p = display_page;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (display_page === p && n < 5000);
    bound(n, 5000);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v;
    logic [7:0] f;
    logic [7:0] tv;
    logic [7:0] old;
    int n;
    int k;
    int j;
    repeat (6) @(posedge clock);
    rst <= 0;
    for (k = 0; k < 8; k++) begin
      peek(RIDX[k], RVAL[k]);
    end
    rd(8'hff, d, r);
    check(r, RESP_SLVERR);
    wr(8'hfe, 8'h55, r);
    check(r, RESP_SLVERR);
    wait_for(0, n);
    wait_for(0, n);
    check(n, FL);
    for (k = 0; k < 6; k++) begin
      v = $random(seed);
      for (j = 0; j < 5; j++) begin
        put(FIDX[j], v);
        peek(FIDX[j], v & FMSK[j]);
      end
    end
    put(IDX_SCROLL, 8'h00);
    put(IDX_DISPLAY_MODE, 8'h00);
    put(IDX_PIXEL_DEPTH, 8'h00);
    put(IDX_LAST_PAGE, 8'h05);
    peek(IDX_LAST_PAGE, 8'h00);
    put(IDX_LAST_PAGE, 8'h01);
    peek(IDX_LAST_PAGE, 8'h01);
    put(IDX_PIXEL_DEPTH, 8'h80);
    put(IDX_LAST_PAGE, 8'h0c);
    peek(IDX_LAST_PAGE, 8'h0c);
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      tv = $random(seed);
      f = {FTOP[k][3], v[6], FTOP[k][1], v[4], k[1:0], k[1:0]};
      put(IDX_PIXEL_DEPTH, k[0] ? 8'h80 : 8'h00);
      @(posedge clock);
      t1_value <= tv;
      t1_load <= 1;
      @(posedge clock);
      t1_load <= 0;
      old = fade_cfg;
      wait_for(0, n);
      put(IDX_FADE, f);
      @(posedge clock);
      check(fade_cfg, old);
      wait_for(0, n);
      repeat (2) @(posedge clock);
      check(fade_cfg, f);
      peek(IDX_FADE, f);
      check(fade_times, {part(tv, f[1:0]), f[4] ? {1'b0, tv, 1'b0} : {2'b00, tv},
        part(tv, f[3:2])});
      check(per_dot_fade, f[7] & !f[5] & !k[0]);
      check(global_fade, f[7] & f[5]);
    end
    // Host keeps fade and scroll off before starting a movie
    put(IDX_FADE, 8'h00);
    put(IDX_SCROLL, 8'h00);
    put(IDX_PAGE_DELAY, 8'h00);
    put(IDX_LAST_PAGE, 8'h03);
    put(IDX_LOOP_COUNT, 8'h01);
    put(IDX_DISPLAY_MODE, 8'h01);
    put(IDX_MOVIE_START, 8'h82);
    wait_for(2, n);
    check(display_page, 4'h2);
    for (k = 0; k < 3; k++) begin
      wait_page(n);
      // First page starts at the entry edge, not on a frame boundary
      if (k == 0) begin
        check(n > 7 * FL && n <= 8 * FL, 1);
      end else begin
        check(n, 8 * FL);
      end
      check(display_page, k[0] ? 4'h2 : 4'h3);
    end
    wait_for(3, n);
    check(display_page, 4'h3);
    put(IDX_LOOP_COUNT, 8'h08);
    put(IDX_MOVIE_START, 8'h00);
    put(IDX_MOVIE_START, 8'h82);
    for (j = 0; j < 5; j++) begin
      wait_page(n);
    end
    check(movie_running, 1'b1);
    put(IDX_LOOP_COUNT, 8'h00);
    wait_for(3, n);
    check(display_page, 4'h3);
    put(IDX_MOVIE_START, 8'h00);
    repeat (2) @(posedge clock);
    check(display_page, 4'h0);
    put(IDX_DISPLAY_MODE, 8'h00);
    put(IDX_PIXEL_DEPTH, 8'h00);
    put(IDX_SCROLL, 8'ha0);
    wait_for(1, n);
    v = {4'h0, scroll_offset};
    wait_for(1, n);
    check(n, 32 * FL);
    check(scroll_offset, (v == 8'h08) ? 8'h00 : v + 8'h01);
    put(IDX_SCROLL, 8'h81);
    wait_for(1, n);
    v = {4'h0, scroll_offset};
    wait_for(1, n);
    check(n, 64 * FL);
    check(scroll_offset, (v == 8'h00) ? 8'h08 : v - 8'h01);
    put(IDX_PIXEL_DEPTH, 8'h80);
    repeat (2) @(posedge clock);
    k = 0;
    repeat (1100) begin
      @(posedge clock);
      if (scroll_step !== 1'b0) k++;
    end
    check(k, 0);
    check(scroll_offset, 4'h0);
    tally_and_finish;
  end
endmodule // tb_top
